/* File: dcmmd_pkg.sv */
package dcmmd_pkg;

	// ****************************************************************
	// address space geometry
	// ****************************************************************
	localparam int ADDR_W = 16;
	localparam int PAGE_W = 7;
	localparam int BLK_W = 13;
	localparam int SYNC_STAGES = 3;
	localparam logic [15:0] ROM_WIN_LO = 16'he000;
	localparam logic [15:0] ROM_BASE = 16'hf800;
	localparam logic [15:0] HOST_RELEASE_ADDR = 16'h002f;
	localparam logic [6:0] INTERNAL_PAGES = 7'h04;
	localparam int GPIO_ROM_EN_BIT = 7;
	localparam int ADDR_HALF_BIT = 15;
	localparam int ADDR_BLK_HI = 14;
	localparam int ADDR_BLK_LO = 13;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic ROM_EN_RST = 1'b1;
	localparam logic STRAP_RST = 1'b0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		DCMMD_SP_PROG,
		DCMMD_SP_DATA,
		DCMMD_SP_IO
	} dcmmd_space_t;

	typedef enum logic [2:0] {
		DCMMD_TGT_NONE,
		DCMMD_TGT_DUAL,
		DCMMD_TGT_SINGLE,
		DCMMD_TGT_SHARED,
		DCMMD_TGT_ROM,
		DCMMD_TGT_EXT
	} dcmmd_target_t;

	typedef enum logic [1:0] {
		DCMMD_FETCH_RAM,
		DCMMD_FETCH_EXT,
		DCMMD_FETCH_ROM
	} dcmmd_fetch_t;

	typedef struct packed {
		logic valid;
		logic wr;
		logic [15:0] addr;
	} dcmmd_req_t;

	typedef struct packed {
		dcmmd_target_t target;
		logic [3:0] block;
		logic [2:0] ext_page;
		logic [12:0] offset;
		logic wr_en;
		logic rd_void;
	} dcmmd_sel_t;

	typedef struct packed {
		logic overlay_enable;
		logic data_upper_ram_enable;
		logic micro_mode_select;
	} dcmmd_mode_t;

endpackage

/* File: dcmmd_decoder.sv */
// Functional notes
// - dual-access ram in 8K-word blocks, two accesses served each machine cycle
// - dual-access ram in data space after reset; overlay bit adds program space
// - single-access ram serves one access per cycle and holds data only
// - single-access ram off after reset; data-ram enable bit maps it into data
// - 128K-word shared program ram gives each subsystem one fetch per cycle
// - cpu writes to shared program ram never modify it
// - enabled 2K boot rom displaces one 8K block of shared program memory
// - clearing gpio bit 7 disables rom, exposes ram block at 0E000h
// - rom enable decided at reset from this subsystem's own rom strap
// - fetch source from external strap and rom strap: ram, external or rom
// - eight 64K program pages; 0-3 internal, 4-7 external
// - page values 8 to 127 alias onto external pages 4 to 7
// - accumulator program read/write use the extra page extension bits
// - lower 32K of each page: external if overlay 0, dual-access ram if 1
// - upper 32K: mode 0 pages 0-3 shared, others external; mode 1 all external
// - data space one 64K page; lower 32K always dual-access ram
// - upper data external if data-ram enable 0, single-access ram if 1
// - io space one 64K page, always routed external
// - with external strap 0, external writes dropped and reads undefined
// - external strap 1 and mode 1: pages 0-3 external, 4-127 alias onto 0-3
// - each core reaches only its own local ram
// - rom enable bit reads 1 after reset
// - host boot mode: host write to 002Fh clears rom enable bit
`timescale 1ns/1ps
`default_nettype none

module dcmmd_decoder
	import dcmmd_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic EXT_STRAP_PIN_I,
	input wire logic ROM_STRAP_PIN_I,
	input wire dcmmd_mode_t MODE_I,
	input wire logic [6:0] PAGE_EXT_I,
	input wire logic [6:0] ACC_PAGE_I,
	input wire logic ACC_PROG_INSTR_I,
	input wire dcmmd_req_t PROG_REQ_I,
	input wire dcmmd_req_t DATA_REQ_I,
	input wire logic DATA_IS_IO_I,
	input wire logic GPIO_WR_I,
	input wire logic [15:0] GPIO_WDATA_I,
	input wire logic HOST_WR_I,
	input wire logic [15:0] HOST_ADDR_I,
	output logic PROG_VALID_O,
	output dcmmd_sel_t PROG_SEL_O,
	output logic DATA_VALID_O,
	output dcmmd_sel_t DATA_SEL_O,
	output logic ROM_EN_O,
	output logic EXT_MODE_O,
	output dcmmd_fetch_t FETCH_SRC_O
);

	// ****************************************************************
	// decode functions
	// ****************************************************************
	// the last two synchroniser stages agree, so the pin has settled
	function automatic logic settled(input logic [SYNC_STAGES-1:0] stages);
		return stages[SYNC_STAGES-1] == stages[SYNC_STAGES-2];
	endfunction

	// page values past the internal range fold onto the four external pages;
	// in micro mode every page is external, so all values fold onto 0..3
	function automatic logic [2:0] fold_page(input logic [6:0] page, input logic micro);
		logic [2:0] folded;
		if (micro) begin
			folded = {1'b0, page[1:0]};
		end else if (page < INTERNAL_PAGES) begin
			folded = page[2:0];
		end else begin
			folded = {1'b1, page[1:0]};
		end
		return folded;
	endfunction

	// with the external strap low nothing answers outside the chip: a write
	// must never reach the pins and read data carries no meaning
	function automatic dcmmd_sel_t gate_ext(input dcmmd_sel_t sel, input logic ext_on);
		dcmmd_sel_t g;
		g = sel;
		if (g.target == DCMMD_TGT_EXT && !ext_on) begin
			g.wr_en = 1'b0;
			g.rd_void = 1'b1;
		end
		return g;
	endfunction

	// no mapping or page logic reaches the other core's ram: each
	// instance serves one core, so local selects stay local
	function automatic dcmmd_sel_t decode_prog(input logic [15:0] addr, input logic [6:0] page,
		input logic wr, input dcmmd_mode_t md, input logic ext_on, input logic rom_on);
		dcmmd_sel_t s;
		s.target = DCMMD_TGT_EXT;
		s.block = {2'b00, addr[ADDR_BLK_HI:ADDR_BLK_LO]};
		s.offset = addr[BLK_W-1:0];
		s.wr_en = wr;
		s.rd_void = 1'b0;
		s.ext_page = fold_page(page, md.micro_mode_select);
		if (!addr[ADDR_HALF_BIT]) begin
			if (md.overlay_enable) begin
				s.target = DCMMD_TGT_DUAL;
			end
		end else if (!md.micro_mode_select && page < INTERNAL_PAGES) begin
			s.target = DCMMD_TGT_SHARED;
			s.block = {page[1:0], addr[ADDR_BLK_HI:ADDR_BLK_LO]};
			s.wr_en = 1'b0;
			if (rom_on && page == 7'h00 && addr >= ROM_WIN_LO) begin
				s.target = (addr >= ROM_BASE) ? DCMMD_TGT_ROM : DCMMD_TGT_NONE;
				s.offset = {2'b00, addr[10:0]};
			end
		end
		return gate_ext(s, ext_on);
	endfunction

	function automatic dcmmd_sel_t decode_data(input logic [15:0] addr, input logic wr, input logic io,
		input dcmmd_mode_t md, input logic ext_on);
		dcmmd_sel_t s;
		s.target = DCMMD_TGT_EXT;
		s.block = {2'b00, addr[ADDR_BLK_HI:ADDR_BLK_LO]};
		s.offset = addr[BLK_W-1:0];
		s.ext_page = 3'h0;
		s.wr_en = wr;
		s.rd_void = 1'b0;
		if (io) begin
			s.target = DCMMD_TGT_EXT;
		end else if (!addr[ADDR_HALF_BIT]) begin
			s.target = DCMMD_TGT_DUAL;
		end else if (md.data_upper_ram_enable) begin
			s.target = DCMMD_TGT_SINGLE;
		end
		return gate_ext(s, ext_on);
	endfunction

	// ****************************************************************
	// strap synchronisers
	// ****************************************************************
	logic [SYNC_STAGES-1:0] ext_sync_ff;
	logic [SYNC_STAGES-1:0] rom_sync_ff;
	logic ext_stable_ff;
	logic rom_stable_ff;
	logic ext_strap_ff;
	logic rom_strap_ff;

	always_ff @(posedge CLOCK_I) begin
		ext_sync_ff <= {ext_sync_ff[SYNC_STAGES-2:0], EXT_STRAP_PIN_I};
	end

	always_ff @(posedge CLOCK_I) begin
		rom_sync_ff <= {rom_sync_ff[SYNC_STAGES-2:0], ROM_STRAP_PIN_I};
	end

	// the filter runs through reset, so a change counts only once the last
	// two stages agree and a glitch lasting one clock never reaches the strap latch
	always_ff @(posedge CLOCK_I) begin
		if (settled(ext_sync_ff)) begin
			ext_stable_ff <= ext_sync_ff[SYNC_STAGES-1];
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (settled(rom_sync_ff)) begin
			rom_stable_ff <= rom_sync_ff[SYNC_STAGES-1];
		end
	end

	// straps are caught while reset is held; the last sample before release
	// stands until the next reset, so pins moving later change nothing.
	// limitation: a strap change needs five reset clocks to reach the latch
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			ext_strap_ff <= ext_stable_ff;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			rom_strap_ff <= rom_stable_ff;
		end
	end

	// ****************************************************************
	// boot rom enable bit
	// ****************************************************************
	logic rom_en_ff;
	logic nxt_rom_en;
	logic rom_active;

	always_comb begin
		nxt_rom_en = rom_en_ff;
		if (GPIO_WR_I) begin
			nxt_rom_en = GPIO_WDATA_I[GPIO_ROM_EN_BIT];
		end
		if (HOST_WR_I && !ext_strap_ff && HOST_ADDR_I == HOST_RELEASE_ADDR) begin
			nxt_rom_en = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			rom_en_ff <= ROM_EN_RST;
		end else begin
			rom_en_ff <= nxt_rom_en;
		end
	end

	// rom only maps in when the rom and external straps are both set and the enable bit has not been cleared
	assign rom_active = rom_en_ff & rom_strap_ff & ext_strap_ff;

	// ****************************************************************
	// access decode
	// ****************************************************************
	logic [6:0] prog_page;
	dcmmd_sel_t nxt_prog_sel;
	dcmmd_sel_t nxt_data_sel;
	dcmmd_fetch_t nxt_fetch;

	// accumulator-addressed program moves carry their own page bits
	assign prog_page = ACC_PROG_INSTR_I ? ACC_PAGE_I : PAGE_EXT_I;

	// program and data ports decode in parallel so both may hit dual-access
	// ram in one cycle; single-access ram is only ever on the data port
	always_comb begin
		nxt_prog_sel = decode_prog(PROG_REQ_I.addr, prog_page, PROG_REQ_I.wr, MODE_I, ext_strap_ff,
			rom_active);
		nxt_data_sel = decode_data(DATA_REQ_I.addr, DATA_REQ_I.wr, DATA_IS_IO_I, MODE_I,
			ext_strap_ff);
	end

	always_comb begin
		if (!ext_strap_ff) begin
			nxt_fetch = DCMMD_FETCH_RAM;
		end else if (rom_strap_ff) begin
			nxt_fetch = DCMMD_FETCH_ROM;
		end else begin
			nxt_fetch = DCMMD_FETCH_EXT;
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	// outputs are flopped for clean timing: the select trails the request by
	// one clock, which the core's machine cycle absorbs
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			PROG_VALID_O <= 1'b0;
		end else begin
			PROG_VALID_O <= PROG_REQ_I.valid;
		end
	end

	// an idle cycle still shows its decode but never carries a write
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			PROG_SEL_O <= '0;
		end else begin
			PROG_SEL_O <= nxt_prog_sel;
			if (!PROG_REQ_I.valid) begin
				PROG_SEL_O.wr_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			DATA_VALID_O <= 1'b0;
		end else begin
			DATA_VALID_O <= DATA_REQ_I.valid;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			DATA_SEL_O <= '0;
		end else begin
			DATA_SEL_O <= nxt_data_sel;
			if (!DATA_REQ_I.valid) begin
				DATA_SEL_O.wr_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			ROM_EN_O <= ROM_EN_RST;
		end else begin
			ROM_EN_O <= rom_en_ff;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			EXT_MODE_O <= STRAP_RST;
		end else begin
			EXT_MODE_O <= ext_strap_ff;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			FETCH_SRC_O <= DCMMD_FETCH_RAM;
		end else begin
			FETCH_SRC_O <= nxt_fetch;
		end
	end

endmodule

`default_nettype wire

/* File: dcmmd_decoder_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dcmmd_decoder_chk
	import dcmmd_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire dcmmd_mode_t MODE_I,
	input wire dcmmd_req_t PROG_REQ_I,
	input wire dcmmd_req_t DATA_REQ_I,
	input wire logic DATA_IS_IO_I,
	input wire logic GPIO_WR_I,
	input wire logic [15:0] GPIO_WDATA_I,
	input wire dcmmd_sel_t PROG_SEL_O,
	input wire dcmmd_sel_t DATA_SEL_O,
	input wire logic ROM_EN_O,
	input wire logic EXT_MODE_O,
	input wire dcmmd_fetch_t FETCH_SRC_O
);
	// ****************
	// map checks
	// ****************
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	a_io_ext: assert property (DATA_REQ_I.valid && DATA_IS_IO_I |=> DATA_SEL_O.target == DCMMD_TGT_EXT)
		else $error("io access not external");
	a_data_lo: assert property (DATA_REQ_I.valid && !DATA_IS_IO_I && !DATA_REQ_I.addr[15] |=>
		DATA_SEL_O.target == DCMMD_TGT_DUAL && DATA_SEL_O.block[1:0] == $past(DATA_REQ_I.addr[14:13]))
		else $error("lower data not dual ram");
	a_data_hi: assert property (DATA_REQ_I.valid && !DATA_IS_IO_I && DATA_REQ_I.addr[15] |=> DATA_SEL_O.target ==
		($past(MODE_I.data_upper_ram_enable) ? DCMMD_TGT_SINGLE : DCMMD_TGT_EXT)) else $error("upper data wrong");
	a_prog_lo: assert property (PROG_REQ_I.valid && !PROG_REQ_I.addr[15] |=> PROG_SEL_O.target ==
		($past(MODE_I.overlay_enable) ? DCMMD_TGT_DUAL : DCMMD_TGT_EXT)) else $error("lower program wrong");
	a_mp_ext: assert property (PROG_REQ_I.valid && PROG_REQ_I.addr[15] && MODE_I.micro_mode_select |=>
		PROG_SEL_O.target == DCMMD_TGT_EXT) else $error("micro mode upper not external");
	a_no_cpu_wr: assert property (PROG_SEL_O.target inside {DCMMD_TGT_SHARED, DCMMD_TGT_ROM} |-> !PROG_SEL_O.wr_en)
		else $error("cpu write to shared");
	a_no_prog_single: assert property (PROG_SEL_O.target != DCMMD_TGT_SINGLE)
		else $error("program access to single ram");
	// the strap output lags the latch by a clock, so it matches the decode one cycle on
	a_ext_void: assert property (DATA_REQ_I.valid ##1 (DATA_SEL_O.target == DCMMD_TGT_EXT && !EXT_MODE_O) |->
		DATA_SEL_O.rd_void && !DATA_SEL_O.wr_en) else $error("external access not voided");
	a_fetch_ram: assert property (!EXT_MODE_O |-> FETCH_SRC_O == DCMMD_FETCH_RAM)
		else $error("fetch source not ram");
	a_rom_rst: assert property ($fell(SYS_RST_I) |-> ROM_EN_O)
		else $error("rom enable low after reset");
	a_gpio_off: assert property (GPIO_WR_I && !GPIO_WDATA_I[GPIO_ROM_EN_BIT] ##1 !GPIO_WR_I |=> !ROM_EN_O)
		else $error("gpio clear ignored");
endmodule
bind dcmmd_decoder dcmmd_decoder_chk u_chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .MODE_I(MODE_I),
	.PROG_REQ_I(PROG_REQ_I), .DATA_REQ_I(DATA_REQ_I), .DATA_IS_IO_I(DATA_IS_IO_I), .GPIO_WR_I(GPIO_WR_I),
	.GPIO_WDATA_I(GPIO_WDATA_I), .PROG_SEL_O(PROG_SEL_O), .DATA_SEL_O(DATA_SEL_O), .ROM_EN_O(ROM_EN_O),
	.EXT_MODE_O(EXT_MODE_O), .FETCH_SRC_O(FETCH_SRC_O));
`default_nettype wire

/* File: dcmmd_cpu_bus.sv */
`timescale 1ns/1ps
`default_nettype none
module dcmmd_cpu_bus
	import dcmmd_pkg::*;
(
	input wire logic clk_i,
	input wire dcmmd_req_t p_cmd_i,
	input wire dcmmd_req_t d_cmd_i,
	output var dcmmd_req_t p_req_o,
	output var dcmmd_req_t d_req_o
);
	// idle bus shows the inverted address, so a stale value never looks valid
	initial p_req_o = '0;
	initial d_req_o = '0;
	always @(posedge clk_i) begin
		p_req_o <= #1 p_cmd_i.valid ? p_cmd_i : {2'h0, ~p_req_o.addr};
		d_req_o <= #1 d_cmd_i.valid ? d_cmd_i : {2'h0, ~d_req_o.addr};
	end
endmodule
`default_nettype wire

/* File: dcmmd_decoder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dcmmd_decoder_tb_top
	import dcmmd_pkg::*;
;
	logic clk = '0, rst = '1, ext = '0, rom = '0, io = '0, acc = '0, gw = '0, hw = '0;
	logic pv, dv, re, em;
	logic [6:0] pg = '0, apg = '0;
	logic [15:0] gd = '1, ha = '0;
	dcmmd_mode_t md = '0;
	dcmmd_req_t pc = '0, dc = '0, preq, dreq;
	dcmmd_sel_t ps, ds;
	dcmmd_fetch_t fs;
	int failures = 0, n_tests = 0;
	always #2 clk = ~clk;
	dcmmd_cpu_bus u_cpu (.clk_i(clk), .p_cmd_i(pc), .d_cmd_i(dc), .p_req_o(preq), .d_req_o(dreq));
	dcmmd_decoder dut (.CLOCK_I(clk), .SYS_RST_I(rst), .EXT_STRAP_PIN_I(ext), .ROM_STRAP_PIN_I(rom),
		.MODE_I(md), .PAGE_EXT_I(pg), .ACC_PAGE_I(apg), .ACC_PROG_INSTR_I(acc), .PROG_REQ_I(preq),
		.DATA_REQ_I(dreq), .DATA_IS_IO_I(io), .GPIO_WR_I(gw), .GPIO_WDATA_I(gd), .HOST_WR_I(hw),
		.HOST_ADDR_I(ha), .PROG_VALID_O(pv), .PROG_SEL_O(ps), .DATA_VALID_O(dv), .DATA_SEL_O(ds),
		.ROM_EN_O(re), .EXT_MODE_O(em), .FETCH_SRC_O(fs));
	// ****************
	// helpers
	// ****************
	task chk(input string n, input logic [24:0] s, input logic [24:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask
	task results;
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task rst_to(input logic x, input logic r);
		@(posedge clk) #1 {ext, rom, rst} = {x, r, 1'h1};
		repeat (6) @(posedge clk);
		#1 rst = '0;
		@(posedge clk) #1;
		chk("rom_en", re, 1'h1);
		chk("ext_mode", em, x);
		chk("fetch", fs, !x ? DCMMD_FETCH_RAM : (r ? DCMMD_FETCH_ROM : DCMMD_FETCH_EXT));
	endtask
	// the bus model adds one cycle, the decoder another
	task go(input dcmmd_req_t p, input dcmmd_req_t d);
		@(posedge clk) #1 {pc, dc} = {p, d};
		@(posedge clk) #1 {pc, dc} = '0;
		@(posedge clk) #1;
		chk("pvalid", pv, p.valid);
		chk("dvalid", dv, d.valid);
	endtask
	task strobe(input logic g, input logic [15:0] a);
		@(posedge clk) #1 {gw, hw, gd, ha} = {g, !g, 16'h0000, a};
		@(posedge clk) #1 {gw, hw} = '0;
		repeat (2) @(posedge clk);
		#1 chk("rom_off", re, 1'h0);
	endtask
	// ****************
	// scenarios
	// ****************
	task t_data;
		rst_to(1'h1, 1'h0);
		go('0, {2'h2, 16'h4000});
		chk("dlo", {ds.target, ds.block}, {DCMMD_TGT_DUAL, 4'h2});
		go('0, {2'h2, 16'h9000});
		chk("dhi0", ds.target, DCMMD_TGT_EXT);
		md.data_upper_ram_enable = '1;
		go('0, {2'h2, 16'h9000});
		chk("dhi1", ds.target, DCMMD_TGT_SINGLE);
		io = '1;
		go('0, {2'h2, 16'h0100});
		chk("io", ds.target, DCMMD_TGT_EXT);
		io = '0;
	endtask
	task t_prog;
		md = '0;
		go({2'h2, 16'h1000}, '0);
		chk("plo0", ps.target, DCMMD_TGT_EXT);
		md.overlay_enable = '1;
		go({2'h2, 16'h1000}, '0);
		chk("plo1", ps.target, DCMMD_TGT_DUAL);
		pg = 7'h01;
		go({2'h3, 16'ha000}, '0);
		chk("shr", {ps.target, ps.block, ps.wr_en}, {DCMMD_TGT_SHARED, 4'h5, 1'h0});
		pg = 7'h09;
		go({2'h2, 16'ha000}, '0);
		chk("alias4", {ps.target, ps.ext_page}, {DCMMD_TGT_EXT, 3'h5});
		md.micro_mode_select = '1;
		pg = 7'h06;
		go({2'h2, 16'ha000}, '0);
		chk("alias0", {ps.target, ps.ext_page}, {DCMMD_TGT_EXT, 3'h2});
		md.micro_mode_select = '0;
		{acc, apg} = {1'h1, 7'h02};
		go({2'h2, 16'h8000}, '0);
		chk("acc", {ps.target, ps.block}, {DCMMD_TGT_SHARED, 4'h8});
		acc = '0;
	endtask
	task t_rom;
		rst_to(1'h1, 1'h1);
		pg = '0;
		go({2'h2, 16'hf800}, '0);
		chk("rom", ps.target, DCMMD_TGT_ROM);
		go({2'h2, 16'he000}, '0);
		chk("gap", ps.target, DCMMD_TGT_NONE);
		strobe(1'h1, 16'h0000);
		go({2'h2, 16'he000}, '0);
		chk("e000", {ps.target, ps.block}, {DCMMD_TGT_SHARED, 4'h3});
	endtask
	task t_void;
		rst_to(1'h0, 1'h1);
		md = '0;
		go('0, {2'h2, 16'h9000});
		chk("rvoid", {ds.target, ds.rd_void}, {DCMMD_TGT_EXT, 1'h1});
		go('0, {2'h3, 16'h9000});
		chk("wdrop", ds.wr_en, 1'h0);
		strobe(1'h0, 16'h002f);
	endtask
	initial begin
		#200000;
		failures++;
		results;
	end
	initial begin
		t_data;
		t_prog;
		t_rom;
		t_void;
		results;
	end
endmodule
`default_nettype wire
